/* File: inc/osc_pkg.sv */
package osc_pkg;

   // ----------------------------------------------------------------
   // Clock rates, all in kHz
   // ----------------------------------------------------------------
   localparam int unsigned CORE_FREQ_KHZ = 100000;  // core_clk, 10 ns period
   localparam int unsigned PLL_FREQ_KHZ  = 16000;   // PLL-locked source
   localparam int unsigned LF_FREQ_KHZ   = 500;     // Low frequency source

   // Phase accumulator width and steps, sized to hold CORE_FREQ_KHZ
   localparam int unsigned ACC_W = 17;
   localparam logic [ACC_W-1:0] ACC_WRAP    = ACC_W'(CORE_FREQ_KHZ);
   localparam logic [ACC_W-1:0] ACC_STEP_HF = ACC_W'(PLL_FREQ_KHZ);
   localparam logic [ACC_W-1:0] ACC_STEP_LF = ACC_W'(LF_FREQ_KHZ);
   localparam logic [ACC_W-1:0] ACC_RESET   = 17'h00000;

   // Source tick spacing in core cycles, used by the checks
   localparam int unsigned LF_PERIOD_CYC = CORE_FREQ_KHZ / LF_FREQ_KHZ;

   // ----------------------------------------------------------------
   // Frequency select codes and postscaler
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_DIV1  = 2'h3;
   localparam logic [1:0] SEL_DIV2  = 2'h2;
   localparam logic [1:0] SEL_DIV4  = 2'h1;
   localparam logic [1:0] SEL_DIV8  = 2'h0;
   localparam logic [1:0] SEL_RESET = SEL_DIV2;

   localparam int unsigned POST_W = 3;
   localparam logic [POST_W-1:0] POST_RESET = 3'h0;
   localparam logic [POST_W-1:0] MASK_DIV1  = 3'h0;
   localparam logic [POST_W-1:0] MASK_DIV2  = 3'h1;
   localparam logic [POST_W-1:0] MASK_DIV4  = 3'h3;
   localparam logic [POST_W-1:0] MASK_DIV8  = 3'h7;

   // Software write of the frequency select field
   typedef struct packed {
      logic       wr;    // One-cycle write strobe
      logic [1:0] data;  // New internal_freq_select value
   } sel_write_t;

   // Postscaler mask for a select code: output on counts where cnt & mask == 0
   function automatic logic [POST_W-1:0] post_mask(input logic [1:0] sel);
      logic [POST_W-1:0] m;
      m = MASK_DIV1;
      unique case (sel)
         SEL_DIV1: m = MASK_DIV1;
         SEL_DIV2: m = MASK_DIV2;
         SEL_DIV4: m = MASK_DIV4;
         SEL_DIV8: m = MASK_DIV8;
      endcase
      return m;
   endfunction

endpackage

/* File: verilog/internal_osc_freq_select.sv */
`timescale 1ns/100ps
module internal_osc_freq_select (
   input  wire logic                core_clk,
   input  wire logic                nrst,
   input  wire logic                pll_enable_cfg,
   input  wire osc_pkg::sel_write_t sel_write,
   output logic                     sys_clk_en,
   output logic [1:0]               internal_freq_select,
   output logic                     pll_active
);
   import osc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ACC_W-1:0]  hf_acc;    // 16 MHz phase accumulator
      logic [ACC_W-1:0]  lf_acc;    // 500 kHz phase accumulator
      logic              hf_tick;   // 16 MHz source enable
      logic              lf_tick;   // 500 kHz source enable
      logic [POST_W-1:0] post_cnt;  // Postscaler count of source ticks
      logic [1:0]        sel;       // internal_freq_select field
      logic              pll;       // Captured pll_enable_cfg
      logic              cfg_done;  // Configuration captured
      logic              en;        // Selected system clock enable
   } osc_state_t;

   localparam osc_state_t STATE_RESET = '{
      hf_acc:   ACC_RESET,
      lf_acc:   ACC_RESET,
      hf_tick:  1'b0,
      lf_tick:  1'b0,
      post_cnt: POST_RESET,
      sel:      SEL_RESET,
      pll:      1'b0,
      cfg_done: 1'b0,
      en:       1'b0
   };

   osc_state_t state_q;
   osc_state_t state_d;

   logic [ACC_W-1:0] hf_sum;
   logic [ACC_W-1:0] lf_sum;
   logic             src_tick;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Fractional dividers make both sources from core_clk; postscaler picks the rate
   always_comb begin
      state_d  = state_q;
      hf_sum   = state_q.hf_acc + ACC_STEP_HF;
      lf_sum   = state_q.lf_acc + ACC_STEP_LF;
      src_tick = 1'b0;

      // Both sources run all the time
      if (hf_sum >= ACC_WRAP) begin
         state_d.hf_acc  = hf_sum - ACC_WRAP;
         state_d.hf_tick = 1'b1;
      end else begin
         state_d.hf_acc  = hf_sum;
         state_d.hf_tick = 1'b0;
      end
      if (lf_sum >= ACC_WRAP) begin
         state_d.lf_acc  = lf_sum - ACC_WRAP;
         state_d.lf_tick = 1'b1;
      end else begin
         state_d.lf_acc  = lf_sum;
         state_d.lf_tick = 1'b0;
      end

      // Configuration is caught once after reset release and then frozen
      if (!state_q.cfg_done) begin
         state_d.pll      = pll_enable_cfg;
         state_d.cfg_done = 1'b1;
      end

      // Multiplexer: configuration chooses the source set
      src_tick = state_q.pll ? state_q.hf_tick : state_q.lf_tick;

      // Postscaler counts source ticks; the current select applies at once
      state_d.en = 1'b0;
      if (src_tick) begin
         state_d.post_cnt = state_q.post_cnt + POST_W'(1);
         state_d.en = ((state_q.post_cnt & post_mask(state_q.sel)) == POST_RESET);
      end

      // Software rewrite of the select field
      if (sel_write.wr) begin
         state_d.sel = sel_write.data;
      end
   end

   // Register the state; reset restores the default select
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= STATE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // All outputs are state flip-flops
   assign sys_clk_en           = state_q.en;
   assign internal_freq_select = state_q.sel;
   assign pll_active           = state_q.pll;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   localparam int LF_GAP = LF_PERIOD_CYC;

   // Outputs hold their reset values one edge after reset is seen low
   reset_outputs_a: assert property (
      @(posedge core_clk)
      !nrst |=> (internal_freq_select == SEL_RESET && !sys_clk_en && !pll_active))
      else $error("outputs not at reset values during reset");

   // Select field is the reset value at the first edge after release
   reset_select_a: assert property (
      @(posedge core_clk) $rose(nrst) |-> (state_q.sel == SEL_RESET))
      else $error("select field not at reset value after reset");

   // A write lands in the next cycle
   sel_write_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      sel_write.wr |=> (state_q.sel == $past(sel_write.data)))
      else $error("select write not taken");

   // Without a write the select field holds
   sel_hold_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      !sel_write.wr |=> $stable(state_q.sel))
      else $error("select field changed without a write");

   // Captured configuration never changes afterwards
   cfg_frozen_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q.cfg_done |=> ($stable(state_q.pll) && state_q.cfg_done))
      else $error("pll configuration changed after capture");

   // 16 MHz source ticks come 6 or 7 cycles apart
   hf_spacing_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q.hf_tick |=> (!state_q.hf_tick) [*5] ##[1:2] state_q.hf_tick)
      else $error("16 MHz source spacing wrong");

   // 500 kHz source ticks come exactly 200 cycles apart
   lf_period_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q.lf_tick |-> ##LF_GAP state_q.lf_tick)
      else $error("500 kHz source period wrong");

   // Divide by 1 on the PLL set passes every 16 MHz tick
   pll_div1_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q.pll && state_q.sel == SEL_DIV1 && state_q.hf_tick) |=> state_q.en)
      else $error("divide by 1 missed a 16 MHz tick");

   // Low set with divide by 1 passes every 500 kHz tick
   lf_div1_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (!state_q.pll && state_q.sel == SEL_DIV1 && state_q.lf_tick) |=> state_q.en)
      else $error("divide by 1 missed a 500 kHz tick");

   // An enable follows a source tick at a postscaler boundary of the live select
   post_boundary_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q.en |-> ($past(src_tick)
                      && (($past(state_q.post_cnt) & post_mask($past(state_q.sel)))
                          == POST_RESET)))
      else $error("enable outside postscaler boundary");

   // Divide by 2 only passes ticks at even postscaler counts
   div2_boundary_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q.en && $past(state_q.sel) == SEL_DIV2)
      |-> (($past(state_q.post_cnt) & MASK_DIV2) == POST_RESET))
      else $error("divide by 2 enable at odd count");

   // Divide by 4 only passes every fourth tick
   div4_boundary_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q.en && $past(state_q.sel) == SEL_DIV4)
      |-> (($past(state_q.post_cnt) & MASK_DIV4) == POST_RESET))
      else $error("divide by 4 enable off boundary");

   // Divide by 8 only passes the tick at postscaler count zero
   div8_boundary_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q.en && $past(state_q.sel) == SEL_DIV8)
      |-> (($past(state_q.post_cnt) & MASK_DIV8) == POST_RESET))
      else $error("divide by 8 enable off boundary");

   // Source ticks are far apart, so the enable is a single-cycle pulse
   en_single_a: assert property (
      @(posedge core_clk) disable iff (!nrst)
      state_q.en |=> !state_q.en)
      else $error("system clock enable longer than one cycle");

   // ----------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------
   // Main scenarios: writes, both sets, slowest ratio, low set at divide by 8
   cover_lf_div8_c: cover property (
      @(posedge core_clk) disable iff (!nrst) !state_q.pll && state_q.sel == SEL_DIV8 && state_q.en);
   cover_write_c: cover property (
      @(posedge core_clk) disable iff (!nrst) sel_write.wr ##1 state_q.en);
   cover_pll_en_c: cover property (
      @(posedge core_clk) disable iff (!nrst) state_q.pll && state_q.en);
   cover_lf_en_c: cover property (
      @(posedge core_clk) disable iff (!nrst) !state_q.pll && state_q.en);

endmodule

/* File: bench/internal_osc_freq_select_test.sv */
`timescale 1ns/100ps
module internal_osc_freq_select_test;
   import osc_pkg::*;

   // ------------------------------------------------------------
   // Stimulus and observation signals
   // ------------------------------------------------------------
   logic                core_clk;
   logic                nrst;
   logic                pll_enable_cfg;
   sel_write_t          sel_write;
   logic                sys_clk_en;
   logic [1:0]          internal_freq_select;
   logic                pll_active;
   int                  n_fail;
   int                  n_checks;

   internal_osc_freq_select i_internal_osc_freq_select (
      .core_clk             (core_clk),
      .nrst                 (nrst),
      .pll_enable_cfg       (pll_enable_cfg),
      .sel_write            (sel_write),
      .sys_clk_en           (sys_clk_en),
      .internal_freq_select (internal_freq_select),
      .pll_active           (pll_active)
   );

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Reset for 16 cycles, strap captured at first edge after release
   task automatic do_reset(input logic cfg);
      @(posedge core_clk);
      #1 nrst = 1'b0;
      pll_enable_cfg = cfg;
      repeat (16) @(posedge core_clk);
      #1 check(internal_freq_select, 32'h2);
      check(pll_active, 32'h0);
      check(sys_clk_en, 32'h0);
      nrst = 1'b1;
      @(posedge core_clk);
      #1 check(pll_active, cfg);
      check(internal_freq_select, 32'h2);
   endtask

   task automatic write_sel(input logic [1:0] d);
      @(posedge core_clk);
      #1 sel_write = '{wr: 1'b1, data: d};
      @(posedge core_clk);
      #1 sel_write.wr = 1'b0;
      check(internal_freq_select, d);
   endtask

   // Count output pulses over a window of whole source periods
   task automatic count_pulses(input int cycles, input int exp);
      int n;
      n = 0;
      repeat (4) @(posedge core_clk);
      repeat (cycles) begin
         @(posedge core_clk);
         #1 if (sys_clk_en === 1'b1) n++;
      end
      check(n, exp);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // High set: 800 cycles hold 128 source ticks of 16 MHz
   task automatic test_high_set();
      logic [1:0] codes [4];
      codes = '{SEL_DIV1, SEL_DIV2, SEL_DIV4, SEL_DIV8};
      do_reset(1'b1);
      count_pulses(800, 64);
      for (int k = 0; k < 4; k++) begin
         write_sel(codes[k]);
         count_pulses(800, 128 >> k);
      end
   endtask

   // Low set: 1600 cycles hold 8 source ticks of 500 kHz; strap flips are ignored
   task automatic test_low_set();
      logic [1:0] codes [4];
      codes = '{SEL_DIV1, SEL_DIV2, SEL_DIV4, SEL_DIV8};
      do_reset(1'b0);
      pll_enable_cfg = 1'b1;
      for (int k = 0; k < 4; k++) begin
         write_sel(codes[k]);
         count_pulses(1600, 8 >> k);
         check(pll_active, 32'h0);
      end
   endtask

   // Back-to-back writes, last one wins, then a mid-run reset restores 10
   task automatic test_rewrite_reset();
      @(posedge core_clk);
      #1 sel_write = '{wr: 1'b1, data: SEL_DIV8};
      @(posedge core_clk);
      #1 sel_write.data = SEL_DIV1;
      @(posedge core_clk);
      #1 sel_write.wr = 1'b0;
      check(internal_freq_select, SEL_DIV1);
      count_pulses(1600, 8);
      do_reset(1'b1);
      count_pulses(800, 64);
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      n_fail = 0;
      n_checks = 0;
      nrst = 1'b0;
      pll_enable_cfg = 1'b1;
      sel_write = '{wr: 1'b0, data: 2'h0};
      test_high_set();
      test_low_set();
      test_rewrite_reset();
      results();
   end

   // Tests take about 13000 cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail++;
      results();
   end
endmodule
